// >>> hw/hbc_defs.svh
// Constants for the data link controller host: device map, field positions, own register map
// Overview of operation
// - Mask write precedes each status read; ones refresh and clear, zeros hold.
// - Polled read is followed by writing back the value ANDed with the mask.
// - Setup selects this controller as link source, enables it, clears legacy enables.
// - Setup masks the four legacy data link interrupts.
// - Receive arms code-change and packet-start; code read when present, stop when cleared.
// - After packet start, arm end or not-empty; read flags then a byte while nonempty.
// - On closing byte keep or drop packet by good flag, rearm packet start.
// - New message starts only after transmit-empty; then arm half-empty interrupt.
// - Bytes written only while transmit-full reads zero; otherwise wait for interrupt.
// - End-of-message bit set before last byte; then arm message-end interrupt.
// - After message end, read transmit underrun flag to judge the packet.
// - Code sending writes the code first, then sets the send-enable bit.
`ifndef HBC_DEFS_SVH
`define HBC_DEFS_SVH
// ************************************************************
// Device register offsets
// ************************************************************
`define HBC_DEV_HCR      8'h00
`define HBC_DEV_HSR      8'h01
`define HBC_DEV_CONTROLLER_EVENT_MASK     8'h02
`define HBC_DEV_RECEIVE_INFO_STATUS     8'h03
`define HBC_DEV_CODE_CHANGE_EVENT     8'h04
`define HBC_DEV_RHFR     8'h05
`define HBC_DEV_TRANSMIT_INFO_STATUS     8'h06
`define HBC_DEV_TRANSMIT_CODE_REGISTER     8'h07
`define HBC_DEV_THFR     8'h08
`define HBC_DEV_TCR1     8'h10
`define HBC_DEV_CCR2     8'h11
`define HBC_DEV_IMR2     8'h12
// ************************************************************
// Device field positions and masks
// ************************************************************
`define HBC_HSR_CODE     7
`define HBC_HSR_PEND     6
`define HBC_HSR_PSTART   5
`define HBC_HSR_RECEIVE_HALF_FULL_EVENT    4
`define HBC_HSR_RNE      3
`define HBC_HSR_TRANSMIT_HALF_EMPTY_EVENT    2
`define HBC_HSR_TNF      1
`define HBC_HSR_MEND     0
`define HBC_HCR_IDLE     5
`define HBC_HCR_EOM      2
`define HBC_RHI_OPEN     3
`define HBC_RHI_CLOSE    2
`define HBC_RHI_GOOD     1
`define HBC_RHI_EMPTY    0
`define HBC_THI_EMPTY    0
`define HBC_THI_FULL     1
`define HBC_THI_UNDER    2
`define HBC_CODE_CHANGE_EVENT_NOW     6
`define HBC_CODE_CHANGE_EVENT_LATCH   7
`define HBC_TRANSMIT_CODE_REGISTER_EN      6
`define HBC_TRANSMIT_CODE_REGISTER_SEND    7
`define HBC_TCR1_SET     8'h04
`define HBC_TRANSMIT_CODE_REGISTER_SET     8'h40
`define HBC_CCR2_CLR     8'h33
`define HBC_IMR2_CLR     8'h1e
`define HBC_STROBE_CYC   2
// ************************************************************
// Own register word indexes
// ************************************************************
`define HBC_REG_CTRL     3'h0
`define HBC_REG_STATUS   3'h1
`define HBC_REG_TXDATA   3'h2
`define HBC_REG_RXDATA   3'h3
`define HBC_REG_CODE     3'h4
`define HBC_REG_EVENTS   3'h5
`endif

// >>> hw/hbc_pkg.sv
// Types for the data link controller host
package hbc_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00000, ST_ACC = 5'b00001, ST_SR1 = 5'b00010, ST_SR2 = 5'b00011,
    ST_SR3 = 5'b00100, ST_EVT0 = 5'b00101, ST_EVT = 5'b00110, ST_UDR = 5'b00111,
    ST_CODE = 5'b01000, ST_RX2 = 5'b01001, ST_RX3 = 5'b01010, ST_TXE = 5'b01011,
    ST_TXF = 5'b01100, ST_TXW = 5'b01101, ST_TXD = 5'b01110, ST_MASK = 5'b01111,
    ST_BOC1 = 5'b10000, ST_BOC2 = 5'b10001, ST_INIT_RD = 5'b10010, ST_INIT_WR = 5'b10011,
    ST_INIT_HCR = 5'b10100
  } hbc_state_t;
  typedef enum logic [1:0] {TX_NONE = 2'b00, TX_FILL = 2'b01, TX_END = 2'b10} hbc_txph_t;
  typedef enum logic [1:0] {PT_IDLE = 2'b00, PT_SETUP = 2'b01, PT_STRB = 2'b10, PT_HOLD = 2'b11} hbc_pst_t;
  typedef struct packed {
    hbc_state_t st, ret, sr_ret;
    logic       acc_wr;
    logic [7:0] acc_addr, acc_wdata, rd, sr_addr, sr_mask, sr_val, evt;
    logic [1:0] idx;
    hbc_txph_t  txph;
    logic       tx_wait, rx_pkt, rx_run;
    logic [2:0] rx_flags;
    logic       init_req, cfg_idle, cfg_rx, setup_done;
    logic       tx_slot, tx_last;
    logic [7:0] tx_byte;
    logic       code_req;
    logic [5:0] code_tx, code_rx;
    logic       code_now, rx_valid;
    logic [10:0] rx_data;
    logic [4:0] events;
    logic       rd_ack;
    logic [31:0] rdata;
  } hbc_regs_t;
  typedef struct packed {
    hbc_pst_t   pst;
    logic [7:0] cnt, addr, dout, rdata;
    logic       oe, cs_b, rd_b, wr_b;
  } hbc_pregs_t;
endpackage

// >>> hw/hbc_if.sv
// Access request channel between the sequencer and the parallel port driver
`timescale 1ns/100ps
`default_nettype none
interface hbc_if;
  logic       req;
  logic       wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       done;
  modport ctrl (output req, wr, addr, wdata, input rdata, done);
  modport port (input req, wr, addr, wdata, output rdata, done);
endinterface
`default_nettype wire

// >>> hw/hbc_port.sv
// Parallel port driver: one register read or write on the device pins per request
`timescale 1ns/100ps
`default_nettype none
`include "hbc_defs.svh"
module hbc_port #(
  parameter int unsigned STROBE_CYC = `HBC_STROBE_CYC
) (
  input  wire logic       ref_clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       ce_in,
  hbc_if.port             acc,
  output logic [7:0]      dev_addr_out,
  output logic [7:0]      dev_data_out,
  output logic            dev_data_oe_out,
  output logic            dev_cs_b_out,
  output logic            dev_rd_b_out,
  output logic            dev_wr_b_out,
  input  wire logic [7:0] dev_data_in
);
  localparam hbc_pkg::hbc_pregs_t PRST = '{pst: hbc_pkg::PT_IDLE, cnt: 8'h00, addr: 8'h00, dout: 8'h00,
                                           rdata: 8'h00, oe: 1'b0, cs_b: 1'b1, rd_b: 1'b1, wr_b: 1'b1};
  hbc_pkg::hbc_pregs_t p;
  hbc_pkg::hbc_pregs_t next_p;

  // ************************************************************
  // Access sequence: setup, strobe, hold
  // ************************************************************
  always_comb begin
    next_p = p;
    unique case (p.pst)
      hbc_pkg::PT_IDLE: begin
        if (acc.req) begin
          next_p.pst  = hbc_pkg::PT_SETUP;
          next_p.cs_b = 1'b0;
          next_p.addr = acc.addr;
          next_p.dout = acc.wdata;
          next_p.oe   = acc.wr;
        end
      end
      hbc_pkg::PT_SETUP: begin
        next_p.pst  = hbc_pkg::PT_STRB;
        next_p.rd_b = acc.wr;
        next_p.wr_b = ~acc.wr;
        next_p.cnt  = 8'(STROBE_CYC - 1);
      end
      hbc_pkg::PT_STRB: begin
        if (p.cnt == 8'h00) begin
          next_p.pst  = hbc_pkg::PT_HOLD;
          next_p.rd_b = 1'b1;
          next_p.wr_b = 1'b1;
          if (!acc.wr) begin
            next_p.rdata = dev_data_in;
          end
        end else begin
          next_p.cnt = p.cnt - 8'h01;
        end
      end
      hbc_pkg::PT_HOLD: begin
        // Data stays driven through hold so the device latches a settled byte
        next_p.pst  = hbc_pkg::PT_IDLE;
        next_p.cs_b = 1'b1;
        next_p.oe   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      p <= PRST;
    end else if (ce_in) begin
      p <= next_p;
    end
  end

  assign acc.done        = (p.pst == hbc_pkg::PT_HOLD);
  assign acc.rdata       = p.rdata;
  assign dev_addr_out    = p.addr;
  assign dev_data_out    = p.dout;
  assign dev_data_oe_out = p.oe;
  assign dev_cs_b_out    = p.cs_b;
  assign dev_rd_b_out    = p.rd_b;
  assign dev_wr_b_out    = p.wr_b;
endmodule
`default_nettype wire

// >>> hw/hbc_ctrl.sv
// Data link controller host: software registers over Avalon-MM and device sequencing
//
// Local design decisions: the address map and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
`include "hbc_defs.svh"
module hbc_ctrl #(
  parameter int unsigned STROBE_CYC = `HBC_STROBE_CYC
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        ce_in,
  input  wire logic [2:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  output logic [7:0]       dev_addr_out,
  input  wire logic [7:0]  dev_data_in,
  output logic [7:0]       dev_data_out,
  output logic             dev_data_oe_out,
  output logic             dev_cs_b_out,
  output logic             dev_rd_b_out,
  output logic             dev_wr_b_out,
  input  wire logic        dev_int_b_in
);
  hbc_pkg::hbc_regs_t r;
  hbc_pkg::hbc_regs_t next_r;
  logic               wr_block;
  logic [23:0]        init_w;
  hbc_if              bus ();

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic hbc_pkg::hbc_regs_t acc_f(input hbc_pkg::hbc_regs_t s, input logic wr,
                                               input logic [7:0] a, input logic [7:0] d,
                                               input hbc_pkg::hbc_state_t ret);
    s.acc_wr    = wr;
    s.acc_addr  = a;
    s.acc_wdata = d;
    s.ret       = ret;
    s.st        = hbc_pkg::ST_ACC;
    return s;
  endfunction

  function automatic hbc_pkg::hbc_regs_t sr_f(input hbc_pkg::hbc_regs_t s, input logic [7:0] a,
                                              input logic [7:0] m, input hbc_pkg::hbc_state_t ret);
    s.sr_addr = a;
    s.sr_mask = m;
    s.sr_ret  = ret;
    s.st      = hbc_pkg::ST_SR1;
    return s;
  endfunction

  function automatic logic [7:0] bit_f(input int unsigned pos);
    bit_f = 8'h01 << pos;
  endfunction

  function automatic logic [7:0] controller_event_mask_f(input logic rx_en, input logic rx_pkt,
                                        input hbc_pkg::hbc_txph_t ph);
    controller_event_mask_f = 8'h00;
    if (rx_en) begin
      controller_event_mask_f[`HBC_HSR_CODE] = 1'b1;
      if (rx_pkt) begin
        controller_event_mask_f[`HBC_HSR_PEND] = 1'b1;
        controller_event_mask_f[`HBC_HSR_RNE]  = 1'b1;
      end else begin
        controller_event_mask_f[`HBC_HSR_PSTART] = 1'b1;
      end
    end
    controller_event_mask_f[`HBC_HSR_TRANSMIT_HALF_EMPTY_EVENT] = (ph == hbc_pkg::TX_FILL);
    controller_event_mask_f[`HBC_HSR_MEND]  = (ph == hbc_pkg::TX_END);
  endfunction

  function automatic logic [7:0] hcr_f(input logic idle, input logic end_of_message_ctl);
    hcr_f = 8'h00;
    hcr_f[`HBC_HCR_IDLE] = idle;
    hcr_f[`HBC_HCR_EOM]  = end_of_message_ctl;
  endfunction

  // Read-modify-write table: address, bits to set, bits to clear
  function automatic logic [23:0] init_f(input logic [1:0] i);
    unique case (i)
      2'h0: init_f = {`HBC_DEV_TCR1, `HBC_TCR1_SET, 8'h00};
      2'h1: init_f = {`HBC_DEV_TRANSMIT_CODE_REGISTER, `HBC_TRANSMIT_CODE_REGISTER_SET, 8'h00};
      2'h2: init_f = {`HBC_DEV_CCR2, 8'h00, `HBC_CCR2_CLR};
      2'h3: init_f = {`HBC_DEV_IMR2, 8'h00, `HBC_IMR2_CLR};
    endcase
  endfunction

  function automatic logic [31:0] rmux_f(input hbc_pkg::hbc_regs_t s, input logic [2:0] a);
    unique case (a)
      `HBC_REG_CTRL:   rmux_f = {29'h0, s.cfg_rx, s.cfg_idle, 1'b0};
      `HBC_REG_STATUS: rmux_f = {24'h0, s.setup_done, s.st != hbc_pkg::ST_IDLE, s.tx_slot, s.tx_wait,
                                 s.rx_valid, s.rx_pkt, s.txph};
      `HBC_REG_RXDATA: rmux_f = {s.rx_valid, 20'h0, s.rx_data};
      `HBC_REG_CODE:   rmux_f = {23'h0, s.code_now, 2'h0, s.code_rx};
      `HBC_REG_EVENTS: rmux_f = {27'h0, s.events};
      default:         rmux_f = 32'h0000_0000;
    endcase
  endfunction

  // ************************************************************
  // Software port and device sequencer
  // ************************************************************
  assign wr_block = ((avs_address_in == `HBC_REG_TXDATA) && r.tx_slot) ||
                    ((avs_address_in == `HBC_REG_CODE) && r.code_req);
  assign init_w = init_f(r.idx);

  always_comb begin
    next_r = r;
    // One wait state on reads keeps read data registered
    next_r.rd_ack = avs_read_in && !r.rd_ack;
    if (avs_read_in && !r.rd_ack) begin
      next_r.rdata = rmux_f(r, avs_address_in);
    end
    if (avs_read_in && r.rd_ack) begin
      // Only what the captured word showed is consumed, so a late arrival survives
      if ((avs_address_in == `HBC_REG_RXDATA) && r.rdata[31]) begin
        next_r.rx_valid = 1'b0;
      end
      if (avs_address_in == `HBC_REG_EVENTS) begin
        next_r.events = r.events & ~r.rdata[4:0];
      end
    end
    if (avs_write_in && !wr_block) begin
      unique case (avs_address_in)
        `HBC_REG_CTRL: begin
          next_r.cfg_idle = avs_writedata_in[1];
          next_r.cfg_rx   = avs_writedata_in[2];
          if (avs_writedata_in[0]) begin
            next_r.init_req = 1'b1;
          end
        end
        `HBC_REG_TXDATA: begin
          next_r.tx_slot = 1'b1;
          next_r.tx_byte = avs_writedata_in[7:0];
          next_r.tx_last = avs_writedata_in[8];
        end
        `HBC_REG_CODE: begin
          next_r.code_req = 1'b1;
          next_r.code_tx  = avs_writedata_in[5:0];
        end
        default: begin
        end
      endcase
    end

    unique case (r.st)
      hbc_pkg::ST_IDLE: begin
        if (r.init_req) begin
          next_r.init_req   = 1'b0;
          next_r.setup_done = 1'b0;
          next_r.idx        = 2'h0;
          next_r.txph       = hbc_pkg::TX_NONE;
          next_r.tx_wait    = 1'b0;
          next_r.rx_pkt     = 1'b0;
          next_r.rx_run     = 1'b0;
          next_r.st         = hbc_pkg::ST_INIT_RD;
        end else if (r.setup_done) begin
          if (r.code_req) begin
            next_r.st = hbc_pkg::ST_BOC1;
          end else if (!dev_int_b_in) begin
            next_r = sr_f(next_r, `HBC_DEV_HSR, controller_event_mask_f(r.cfg_rx, r.rx_pkt, r.txph), hbc_pkg::ST_EVT0);
          end else if (r.rx_run && !r.rx_valid) begin
            next_r = sr_f(next_r, `HBC_DEV_RECEIVE_INFO_STATUS, 8'hff, hbc_pkg::ST_RX2);
          end else if (r.tx_slot && !r.tx_wait && (r.txph == hbc_pkg::TX_NONE)) begin
            next_r = sr_f(next_r, `HBC_DEV_TRANSMIT_INFO_STATUS, bit_f(`HBC_THI_EMPTY), hbc_pkg::ST_TXE);
          end else if (r.tx_slot && !r.tx_wait && (r.txph == hbc_pkg::TX_FILL)) begin
            next_r = sr_f(next_r, `HBC_DEV_TRANSMIT_INFO_STATUS, bit_f(`HBC_THI_FULL), hbc_pkg::ST_TXF);
          end
        end
      end
      hbc_pkg::ST_ACC: begin
        if (bus.done) begin
          next_r.rd = bus.rdata;
          next_r.st = r.ret;
        end
      end
      hbc_pkg::ST_SR1: next_r = acc_f(next_r, 1'b1, r.sr_addr, r.sr_mask, hbc_pkg::ST_SR2);
      hbc_pkg::ST_SR2: next_r = acc_f(next_r, 1'b0, r.sr_addr, 8'h00, hbc_pkg::ST_SR3);
      hbc_pkg::ST_SR3: begin
        // Write-back clears bits that latched between mask write and read
        next_r.sr_val = r.rd & r.sr_mask;
        next_r = acc_f(next_r, 1'b1, r.sr_addr, r.rd & r.sr_mask, r.sr_ret);
      end
      hbc_pkg::ST_EVT0: begin
        next_r.evt = r.sr_val;
        next_r.st  = hbc_pkg::ST_EVT;
      end
      hbc_pkg::ST_EVT: begin
        if (r.evt[`HBC_HSR_MEND]) begin
          next_r.evt[`HBC_HSR_MEND] = 1'b0;
          if (r.txph == hbc_pkg::TX_END) begin
            next_r = sr_f(next_r, `HBC_DEV_TRANSMIT_INFO_STATUS, bit_f(`HBC_THI_UNDER), hbc_pkg::ST_UDR);
          end
        end else if (r.evt[`HBC_HSR_CODE]) begin
          next_r.evt[`HBC_HSR_CODE] = 1'b0;
          next_r = sr_f(next_r, `HBC_DEV_CODE_CHANGE_EVENT, 8'hff, hbc_pkg::ST_CODE);
        end else if (r.evt[`HBC_HSR_PSTART]) begin
          next_r.evt[`HBC_HSR_PSTART] = 1'b0;
          next_r.rx_pkt = 1'b1;
          next_r.rx_run = 1'b1;
          next_r.st     = hbc_pkg::ST_MASK;
        end else if (r.evt[`HBC_HSR_PEND] || r.evt[`HBC_HSR_RNE] || r.evt[`HBC_HSR_RECEIVE_HALF_FULL_EVENT]) begin
          next_r.evt = r.evt & ~(bit_f(`HBC_HSR_PEND) | bit_f(`HBC_HSR_RNE) | bit_f(`HBC_HSR_RECEIVE_HALF_FULL_EVENT));
          next_r.rx_run = r.rx_pkt;
        end else if (r.evt[`HBC_HSR_TRANSMIT_HALF_EMPTY_EVENT] || r.evt[`HBC_HSR_TNF]) begin
          next_r.evt = r.evt & ~(bit_f(`HBC_HSR_TRANSMIT_HALF_EMPTY_EVENT) | bit_f(`HBC_HSR_TNF));
          next_r.tx_wait = 1'b0;
        end else begin
          next_r.st = hbc_pkg::ST_IDLE;
        end
      end
      hbc_pkg::ST_UDR: begin
        next_r.events[0] = 1'b1;
        next_r.events[1] = next_r.events[1] | r.sr_val[`HBC_THI_UNDER];
        next_r.txph      = hbc_pkg::TX_NONE;
        next_r.st        = hbc_pkg::ST_MASK;
      end
      hbc_pkg::ST_CODE: begin
        if (r.sr_val[`HBC_CODE_CHANGE_EVENT_LATCH]) begin
          next_r.code_rx = r.sr_val[5:0];
        end
        next_r.code_now  = r.sr_val[`HBC_CODE_CHANGE_EVENT_NOW];
        next_r.events[4] = 1'b1;
        next_r.st        = hbc_pkg::ST_EVT;
      end
      hbc_pkg::ST_RX2: begin
        if (r.sr_val[`HBC_RHI_EMPTY]) begin
          next_r.rx_run = 1'b0;
          next_r.st     = hbc_pkg::ST_IDLE;
        end else begin
          next_r.rx_flags = {r.sr_val[`HBC_RHI_OPEN], r.sr_val[`HBC_RHI_CLOSE], r.sr_val[`HBC_RHI_GOOD]};
          next_r = acc_f(next_r, 1'b0, `HBC_DEV_RHFR, 8'h00, hbc_pkg::ST_RX3);
        end
      end
      hbc_pkg::ST_RX3: begin
        next_r.rx_valid = 1'b1;
        next_r.rx_data  = {r.rx_flags, r.rd};
        next_r.st       = hbc_pkg::ST_IDLE;
        if (r.rx_flags[1]) begin
          next_r.events[2] = next_r.events[2] | r.rx_flags[0];
          next_r.events[3] = next_r.events[3] | ~r.rx_flags[0];
          next_r.rx_pkt    = 1'b0;
          next_r.rx_run    = 1'b0;
          next_r.st        = hbc_pkg::ST_MASK;
        end
      end
      hbc_pkg::ST_TXE: begin
        next_r.st = hbc_pkg::ST_IDLE;
        if (r.sr_val[`HBC_THI_EMPTY]) begin
          next_r.txph = hbc_pkg::TX_FILL;
          next_r.st   = hbc_pkg::ST_MASK;
        end
      end
      hbc_pkg::ST_TXF: begin
        if (r.sr_val[`HBC_THI_FULL]) begin
          next_r.tx_wait = 1'b1;
          next_r.st      = hbc_pkg::ST_IDLE;
        end else if (r.tx_last) begin
          // Device drops the end bit itself after the last byte leaves
          next_r = acc_f(next_r, 1'b1, `HBC_DEV_HCR, hcr_f(r.cfg_idle, 1'b1), hbc_pkg::ST_TXW);
        end else begin
          next_r.st = hbc_pkg::ST_TXW;
        end
      end
      hbc_pkg::ST_TXW: next_r = acc_f(next_r, 1'b1, `HBC_DEV_THFR, r.tx_byte, hbc_pkg::ST_TXD);
      hbc_pkg::ST_TXD: begin
        next_r.tx_slot = 1'b0;
        next_r.st      = hbc_pkg::ST_IDLE;
        if (r.tx_last) begin
          next_r.txph = hbc_pkg::TX_END;
          next_r.st   = hbc_pkg::ST_MASK;
        end
      end
      hbc_pkg::ST_MASK: begin
        next_r = acc_f(next_r, 1'b1, `HBC_DEV_CONTROLLER_EVENT_MASK, controller_event_mask_f(r.cfg_rx, r.rx_pkt, r.txph), hbc_pkg::ST_IDLE);
      end
      hbc_pkg::ST_BOC1: begin
        next_r = acc_f(next_r, 1'b1, `HBC_DEV_TRANSMIT_CODE_REGISTER, bit_f(`HBC_TRANSMIT_CODE_REGISTER_EN) | {2'h0, r.code_tx},
                       hbc_pkg::ST_BOC2);
      end
      hbc_pkg::ST_BOC2: begin
        next_r.code_req = 1'b0;
        next_r = acc_f(next_r, 1'b1, `HBC_DEV_TRANSMIT_CODE_REGISTER,
                       bit_f(`HBC_TRANSMIT_CODE_REGISTER_EN) | bit_f(`HBC_TRANSMIT_CODE_REGISTER_SEND) | {2'h0, r.code_tx},
                       hbc_pkg::ST_IDLE);
      end
      hbc_pkg::ST_INIT_RD: begin
        next_r = acc_f(next_r, 1'b0, init_w[23:16], 8'h00, hbc_pkg::ST_INIT_WR);
      end
      hbc_pkg::ST_INIT_WR: begin
        next_r.idx = r.idx + 2'h1;
        next_r = acc_f(next_r, 1'b1, init_w[23:16], (r.rd & ~init_w[7:0]) | init_w[15:8],
                       (r.idx == 2'h3) ? hbc_pkg::ST_INIT_HCR : hbc_pkg::ST_INIT_RD);
      end
      hbc_pkg::ST_INIT_HCR: begin
        next_r.setup_done = 1'b1;
        next_r = acc_f(next_r, 1'b1, `HBC_DEV_HCR, hcr_f(r.cfg_idle, 1'b0), hbc_pkg::ST_MASK);
      end
      default: next_r.st = hbc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      r <= '0;
    end else if (ce_in) begin
      r <= next_r;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign bus.req   = (r.st == hbc_pkg::ST_ACC);
  assign bus.wr    = r.acc_wr;
  assign bus.addr  = r.acc_addr;
  assign bus.wdata = r.acc_wdata;
  assign avs_readdata_out    = r.rdata;
  assign avs_waitrequest_out = !ce_in || (avs_read_in && !r.rd_ack) || (avs_write_in && wr_block);

  hbc_port #(
    .STROBE_CYC (STROBE_CYC)
  ) u_port (
    .ref_clk_in      (ref_clk_in),
    .rst_b_in        (rst_b_in),
    .ce_in           (ce_in),
    .acc             (bus.port),
    .dev_addr_out    (dev_addr_out),
    .dev_data_out    (dev_data_out),
    .dev_data_oe_out (dev_data_oe_out),
    .dev_cs_b_out    (dev_cs_b_out),
    .dev_rd_b_out    (dev_rd_b_out),
    .dev_wr_b_out    (dev_wr_b_out),
    .dev_data_in     (dev_data_in)
  );
endmodule
`default_nettype wire

// >>> sim/hbc_ctrl_monitor.sv
// Pin protocol checks for the data link controller host
`timescale 1ns/100ps
`default_nettype none
module hbc_ctrl_monitor #(
  parameter int unsigned STROBE_CYC = 2
) (
  input wire logic       ref_clk_in,
  input wire logic       rst_b_in,
  input wire logic       avs_read_in,
  input wire logic       avs_waitrequest_out,
  input wire logic [7:0] dev_addr_out,
  input wire logic       dev_data_oe_out,
  input wire logic       dev_cs_b_out,
  input wire logic       dev_rd_b_out,
  input wire logic       dev_wr_b_out
);
  logic [7:0] strb_cnt;
  logic [7:0] next_strb_cnt;
  always_comb next_strb_cnt = (dev_rd_b_out && dev_wr_b_out) ? 8'h00 : strb_cnt + 8'h01;
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) strb_cnt <= 8'h00;
    else strb_cnt <= next_strb_cnt;
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_strobe_end;
    $rose(dev_rd_b_out) || $rose(dev_wr_b_out);
  endsequence
  a_read_wait: assert property ($rose(avs_read_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
    else $error("read wait state wrong");
  a_strobe_len: assert property (s_strobe_end |-> strb_cnt == STROBE_CYC)
    else $error("strobe length wrong");
  a_strobe_in_cs: assert property (!(dev_rd_b_out && dev_wr_b_out) |-> !dev_cs_b_out)
    else $error("strobe outside select");
  a_one_strobe: assert property (dev_rd_b_out || dev_wr_b_out)
    else $error("read and write strobes together");
  a_oe_dir: assert property (!(dev_rd_b_out && dev_wr_b_out) |-> dev_data_oe_out == !dev_wr_b_out)
    else $error("data enable against direction");
  a_addr_hold: assert property (!dev_cs_b_out && !$past(dev_cs_b_out) |-> $stable(dev_addr_out))
    else $error("address moved in access");
  a_cs_gap: assert property ($rose(dev_cs_b_out) |=> dev_cs_b_out)
    else $error("no idle cycle between accesses");
  a_cs_close: assert property (s_strobe_end |-> ##[1:2] dev_cs_b_out)
    else $error("select not released after strobe");
endmodule
bind hbc_ctrl hbc_ctrl_monitor #(.STROBE_CYC(STROBE_CYC)) u_hbc_ctrl_monitor (.ref_clk_in, .rst_b_in,
  .avs_read_in, .avs_waitrequest_out, .dev_addr_out, .dev_data_oe_out, .dev_cs_b_out, .dev_rd_b_out, .dev_wr_b_out);
`default_nettype wire

// >>> sim/hbc_dev_model.sv
// Behavioural device: register file behind the parallel port
`timescale 1ns/100ps
`default_nettype none
module hbc_dev_model (
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] data_in,
  input  wire logic       cs_b_in,
  input  wire logic       rd_b_in,
  input  wire logic       wr_b_in,
  output logic      [7:0] data_out,
  output logic            int_b_out
);
  logic [7:0] mem [256];
  logic [7:0] last;
  logic [7:0] transmit_code_register_prev;
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    mem[8'h11] = 8'hff;
    mem[8'h12] = 8'hff;
    last = 8'h00;
  end
  // Taken as the write strobe closes; the old code word is kept to see the order
  // Transmit side is always empty, never full, never underrun: a status write only selects bits
  always @(posedge wr_b_in) begin
    if (!cs_b_in) mem[addr_in] <= (addr_in == 8'h06) ? (data_in & 8'h01) : data_in;
    if (!cs_b_in && addr_in == 8'h07) transmit_code_register_prev <= mem[8'h07];
    if (!cs_b_in && addr_in == 8'h08) mem[8'h00][2] <= 1'b0;
  end
  always @(posedge rd_b_in) last <= mem[addr_in];
  // Released bus shows the inverse so a stale sample cannot pass
  assign data_out = (!cs_b_in && !rd_b_in) ? mem[addr_in] : ~last;
  assign int_b_out = 1'b1;
endmodule
`default_nettype wire

// >>> sim/hbc_ctrl_tb_top.sv
// Bench: setup and code send sequences against the device model
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module hbc_ctrl_tb_top;
  logic ref_clk_in = 1'b0, rst_b_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0, dev_int_b_in;
  logic [2:0] avs_address_in = 3'h0;
  logic [31:0] avs_writedata_in = 32'h0000_0000, avs_readdata_out, rd;
  logic avs_waitrequest_out, dev_data_oe_out, dev_cs_b_out, dev_rd_b_out, dev_wr_b_out;
  logic [7:0] dev_addr_out, dev_data_in, dev_data_out;
  int fails = 0, n_checks = 0;
  always #25 ref_clk_in = ~ref_clk_in;
  hbc_ctrl #(.STROBE_CYC(2)) u_hbc_ctrl (.ref_clk_in, .rst_b_in, .ce_in(1'b1), .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .dev_addr_out, .dev_data_in,
    .dev_data_out, .dev_data_oe_out, .dev_cs_b_out, .dev_rd_b_out, .dev_wr_b_out, .dev_int_b_in);
  hbc_dev_model u_hbc_dev_model (.addr_in(dev_addr_out), .data_in(dev_data_out), .cs_b_in(dev_cs_b_out),
    .rd_b_in(dev_rd_b_out), .wr_b_in(dev_wr_b_out), .data_out(dev_data_in), .int_b_out(dev_int_b_in));
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    avs_write_in <= wr;
    avs_read_in <= !wr;
    avs_address_in <= a;
    avs_writedata_in <= d;
    do @(posedge ref_clk_in); while (avs_waitrequest_out !== 1'b0);
    rd = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #2000000;
    fails++;
    summarize();
  end
  initial begin
    repeat (6) @(posedge ref_clk_in);
    `CHK({dev_cs_b_out, dev_rd_b_out, dev_wr_b_out, dev_data_oe_out}, 4'b1110)
    rst_b_in <= 1'b1;
    bus(1'b0, 3'h1, 32'h0000_0000);
    `CHK(rd[7], 1'b0)
    bus(1'b0, 3'h6, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    $display("test reset done");
    // Idle select bit set so the control write reads back as 20h, not zero
    bus(1'b1, 3'h0, 32'h0000_0003);
    // Setup is over only once done is set and the sequencer has gone idle
    for (int i = 0; i < 400 && rd[7:6] !== 2'b10; i++) bus(1'b0, 3'h1, 32'h0000_0000);
    `CHK(rd[7:6], 2'b10)
    `CHK(u_hbc_dev_model.mem[8'h10], 8'h04)
    `CHK(u_hbc_dev_model.mem[8'h07], 8'h40)
    `CHK(u_hbc_dev_model.mem[8'h11], 8'hcc)
    `CHK(u_hbc_dev_model.mem[8'h12], 8'he1)
    `CHK(u_hbc_dev_model.mem[8'h00], 8'h20)
    $display("test setup done");
    bus(1'b1, 3'h4, 32'h0000_002a);
    // Second code is held off until the send-enable write of the first is queued
    bus(1'b1, 3'h4, 32'h0000_0015);
    for (int i = 0; i < 400 && u_hbc_dev_model.mem[8'h07] !== 8'hea; i++) @(posedge ref_clk_in);
    `CHK(u_hbc_dev_model.mem[8'h07], 8'hea)
    for (int i = 0; i < 400 && u_hbc_dev_model.mem[8'h07] !== 8'hd5; i++) @(posedge ref_clk_in);
    `CHK(u_hbc_dev_model.mem[8'h07], 8'hd5)
    `CHK(u_hbc_dev_model.transmit_code_register_prev, 8'h55)
    $display("test code done");
    // One-byte packet: empty check, full check, end bit, byte, message-end armed
    bus(1'b1, 3'h2, 32'h0000_015a);
    for (int i = 0; i < 400 && rd[7:0] !== 8'h82; i++) bus(1'b0, 3'h1, 32'h0000_0000);
    `CHK(rd, 32'h0000_0082)
    `CHK(u_hbc_dev_model.mem[8'h08], 8'h5a)
    `CHK(u_hbc_dev_model.mem[8'h02], 8'h01)
    `CHK(u_hbc_dev_model.mem[8'h00], 8'h20)
    $display("test transmit done");
    summarize();
  end
endmodule
`default_nettype wire
